// ---- pwt_consts.svh ----
// Constants for the power waveform timer: offsets, fields, resets, counts
// Contract
// - Waveform counter is twelve bits wide.
// - Counter ticks from RC oscillator, external clock or system clock, by select field.
// - Counter core runs apart from the bus-side logic behind handshakes, on the same aclk.
// - Set and clear compares are byte pairs, double buffered, moved to core on the next control write or, while enabled, command write.
// - Two units drive own outputs; two extra outputs mirror either unit.
// - Two complementary waveform outputs, each with optional dead time.
// - Counter compared continuously; match and cycle end raise events.
// - Ten input modes, chosen per event input, steer outputs and counter.
// - Two capture channels, each holding its captured value double buffered.
// - Event inputs pass a programmable filter before use, except the async kill, which takes the raw input.
// - Debug halt stops counter and waveforms unless run-in-debug is set.
// - Fault inject during debug halt asserts fault on both event channels.
// - Each waveform cycle passes four states before returning.
// - Ramp modes zero the counter once, twice or four times per cycle.
// - Dual-slope counts up to top then back down.
// - Blanking ignores events, except the async kill, for programmable time in selectable cycle part.
// - Non-recoverable fault event overrides outputs at once, without clock edge.
// - Hardware emergency stop of outputs on fault, no software needed.
// - Outputs can drive a half bridge or a full bridge.
// - Standard order is dead first, on first, dead second, on second.
// - One ramp counts to unit-two clear value, restarts at zero.
// - Disable by clearing enable, or at cycle end by strobe.
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH
`define PWT_CNT_W      12
`define PWT_ADDR_W     8
`define PWT_OFF_CTRL   8'h00
`define PWT_OFF_CMD    8'h04
`define PWT_OFF_STATUS 8'h08
`define PWT_OFF_U1SET  8'h0C
`define PWT_OFF_U1CLR  8'h10
`define PWT_OFF_U2SET  8'h14
`define PWT_OFF_U2CLR  8'h18
`define PWT_OFF_INCFG  8'h1C
`define PWT_OFF_CAP1   8'h20
`define PWT_OFF_CAP2   8'h24
`define PWT_OFF_COUNT  8'h28
`define PWT_CMD_EOC    1
`define PWT_CMD_RST    2
`define PWT_CMD_CAP1   3
`define PWT_CMD_CAP2   4
`define PWT_CMD_W      5
`define PWT_ST_FLAG_LO 3
`define PWT_CTRL_W     10
`define PWT_INCFG_W    28
`define PWT_CTRL_RST   10'h000
`define PWT_INCFG_RST  28'h0000000
`define PWT_CNT_RST    12'h000
`define PWT_RESP_OK    2'h0
`define PWT_RESP_ERR   2'h2
`endif

// ---- pwt_pkg.sv ----
// Types shared by the power waveform timer files
`include "pwt_consts.svh"
package pwt_pkg;
	typedef enum logic [3:0] {
		PWT_DT1 = 4'b0001,
		PWT_OT1 = 4'b0010,
		PWT_DT2 = 4'b0100,
		PWT_OT2 = 4'b1000
	} pwt_state_t;
	typedef enum logic [1:0] {
		PWT_ONE = 2'h0, PWT_TWO = 2'h1, PWT_FOUR = 2'h2, PWT_DUAL = 2'h3
	} pwt_wave_t;
	typedef enum logic [1:0] {
		PWT_SRC_RC = 2'h0, PWT_SRC_EXT = 2'h1, PWT_SRC_SYS = 2'h2, PWT_SRC_OFF = 2'h3
	} pwt_src_t;
	typedef enum logic [3:0] {
		PWT_IN_OFF = 4'h0, PWT_IN_CAP = 4'h1, PWT_IN_RST = 4'h2, PWT_IN_SKIP = 4'h3,
		PWT_IN_GATE = 4'h4, PWT_IN_GATE_RST = 4'h5, PWT_IN_LATCH = 4'h6,
		PWT_IN_CAP_RST = 4'h7, PWT_IN_ASYNC = 4'h8, PWT_IN_HALT = 4'h9
	} pwt_in_mode_t;
	typedef struct packed {
		logic      fourth_sel;
		logic      third_sel;
		logic      full_bridge;
		logic      fault_inj;
		logic      run_dbg;
		pwt_wave_t wave;
		pwt_src_t  src;
		logic      enable;
	} pwt_ctrl_t;
	typedef struct packed {
		logic [`PWT_CNT_W-1:0] u2clr;
		logic [`PWT_CNT_W-1:0] u2set;
		logic [`PWT_CNT_W-1:0] u1clr;
		logic [`PWT_CNT_W-1:0] u1set;
	} pwt_cmp_t;
	typedef struct packed {
		logic [`PWT_CNT_W-1:0] blank_len;
		logic [3:0]            blank_win;
		logic [3:0]            filt;
		pwt_in_mode_t          mode2;
		pwt_in_mode_t          mode1;
	} pwt_incfg_t;
	typedef struct packed {
		pwt_ctrl_t ctrl;
		pwt_cmp_t  cmp;
		logic      eoc;
		logic      restart;
		logic      cap1;
		logic      cap2;
	} pwt_xfer_t;
	typedef struct packed {
		logic gate;
		logic restart;
		logic skip;
		logic capture;
		logic halt;
		logic latch;
		logic async_kill;
	} pwt_act_t;
endpackage

// ---- pwt_hs_sync.sv ----
// Toggle handshake carrying a held word from one side to the other
`timescale 1ns/10ps
module pwt_hs_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// Source side
	input  wire logic         src_load,
	input  wire logic [W-1:0] src_data,
	output logic              src_busy,
	// Destination side
	output logic              dst_valid,
	output logic [W-1:0]      dst_data
);
	logic [W-1:0] hold;
	logic         req;
	logic [1:0]   ack_s;
	logic [1:0]   req_s;
	logic         req_seen;

	initial if (W < 1) $error("pwt_hs_sync: W must be at least 1");

	// Busy until the destination acknowledges; hold never moves meanwhile
	assign src_busy = req ^ ack_s[1];

	// Source: launch a word, watch the acknowledge come back
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			hold  <= '0;
			req   <= 1'b0;
			ack_s <= 2'b00;
		end
		else if (ce)
		begin
			if (src_load && !src_busy)
			begin
				hold <= src_data;
				req  <= ~req;
			end
			ack_s <= {ack_s[0], req_seen};
		end

	// Destination: a toggle of the request marks a stable word
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			req_s     <= 2'b00;
			req_seen  <= 1'b0;
			dst_valid <= 1'b0;
			dst_data  <= '0;
		end
		else if (ce)
		begin
			req_s     <= {req_s[0], req};
			req_seen  <= req_s[1];
			dst_valid <= req_s[1] ^ req_seen;
			if (req_s[1] ^ req_seen)
				dst_data <= hold;
		end
endmodule

// ---- pwt_top.sv ----
// Power waveform timer: AXI4-Lite registers, counter core, four waveform outputs
`timescale 1ns/10ps
`include "pwt_consts.svh"
module pwt_top #(
	parameter int CNT_W = `PWT_CNT_W
) (
	// Clock, reset, clock enable
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   ce,
	// AXI4-Lite slave
	input  wire logic [`PWT_ADDR_W-1:0] awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [`PWT_ADDR_W-1:0] araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// Counter clock sources, sampled levels
	input  wire logic                   internal_rc_oscillator,
	input  wire logic                   ext_clk_in,
	// Debug and event inputs
	input  wire logic                   dbg_halt,
	input  wire logic [1:0]             event_in,
	// Waveform outputs and event pulses
	output logic                        wave_out_first,
	output logic                        wave_out_second,
	output logic                        wave_out_third,
	output logic                        wave_out_fourth,
	output logic                        evt_match1,
	output logic                        evt_match2,
	output logic                        evt_cycle_end
);
	import pwt_pkg::*;

	initial if (CNT_W != `PWT_CNT_W) $error("pwt_top: counter width is fixed");

	// Bus side state
	logic                   aw_full;
	logic                   w_full;
	logic [`PWT_ADDR_W-1:0] aw_a;
	logic [31:0]            w_d;
	logic [3:0]             w_s;
	pwt_ctrl_t              ctrl_q;
	pwt_cmp_t               cmp_q;
	pwt_incfg_t             incfg_q;
	logic [`PWT_CMD_W-1:0]  cmd_q;
	logic                   launch;
	logic [2:0]             flags;
	logic [CNT_W-1:0]       cap1_b;
	logic [CNT_W-1:0]       cap2_b;
	// Core side state
	pwt_ctrl_t              core_ctrl;
	pwt_cmp_t               core_cmp;
	pwt_state_t             state;
	logic [CNT_W-1:0]       cnt;
	logic                   down;
	logic                   core_run;
	logic                   eoc_pend;
	logic                   fault_lat;
	logic [CNT_W-1:0]       blank_cnt;
	logic [CNT_W-1:0]       cap1_c;
	logic [CNT_W-1:0]       cap2_c;
	logic                   cap_pend;
	logic                   rc_q;
	logic                   ext_q;
	logic                   o1_q;
	logic                   o2_q;
	logic                   o3_q;
	logic                   o4_q;
	// Event path per channel
	logic [1:0]             raw;
	logic [1:0]             filt_lvl;
	logic [3:0]             filt_cnt [2];
	logic [1:0]             evt;
	logic [1:0]             evt_q;
	logic [1:0]             rise;
	pwt_act_t               act [2];
	pwt_in_mode_t           mode [2];
	logic [1:0]             gate_v;
	logic [1:0]             rst_v;
	logic [1:0]             skip_v;
	logic [1:0]             cap_v;
	logic [1:0]             halt_v;
	logic [1:0]             latch_v;
	logic [1:0]             akill_v;

	// Input mode decode; level actions versus edge actions
	function automatic pwt_act_t mode_act(input pwt_in_mode_t m);
		mode_act = '0;
		case (m)
			PWT_IN_CAP:      mode_act.capture = 1'b1;
			PWT_IN_RST:      mode_act.restart = 1'b1;
			PWT_IN_SKIP:     mode_act.skip = 1'b1;
			PWT_IN_GATE:     mode_act.gate = 1'b1;
			PWT_IN_GATE_RST:
			begin
				mode_act.gate    = 1'b1;
				mode_act.restart = 1'b1;
			end
			PWT_IN_LATCH:    mode_act.latch = 1'b1;
			PWT_IN_CAP_RST:
			begin
				mode_act.capture = 1'b1;
				mode_act.restart = 1'b1;
			end
			PWT_IN_ASYNC:
			begin
				mode_act.async_kill = 1'b1;
				mode_act.latch      = 1'b1;
			end
			PWT_IN_HALT:     mode_act.halt = 1'b1;
			default:         mode_act = '0;
		endcase
	endfunction

	// Address decode shared by reads and writes
	function automatic logic is_mapped(input logic [`PWT_ADDR_W-1:0] a);
		is_mapped = (a <= `PWT_OFF_COUNT) && (a[1:0] == 2'b00);
	endfunction

	// Handshake wires
	pwt_xfer_t xout;
	pwt_xfer_t xin;
	logic      xv;
	logic      hs_busy;
	logic      busy;
	logic      cap_busy;
	logic      cap_v_b;
	logic      cap_load;
	logic [2*CNT_W-1:0] cap_in;

	assign busy = launch | hs_busy;
	assign xout = '{ctrl: ctrl_q, cmp: cmp_q, eoc: cmd_q[`PWT_CMD_EOC],
		restart: cmd_q[`PWT_CMD_RST], cap1: cmd_q[`PWT_CMD_CAP1], cap2: cmd_q[`PWT_CMD_CAP2]};
	assign cap_load = cap_pend & ~cap_busy;

	// Control and compares into the core, one packet at a time
	pwt_hs_sync #(.W($bits(pwt_xfer_t))) u_cfg_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.src_load  (launch),
		.src_data  (xout),
		.src_busy  (hs_busy),
		.dst_valid (xv),
		.dst_data  (xin)
	);

	// Captured values back to the bus side as one word pair
	pwt_hs_sync #(.W(2*CNT_W)) u_cap_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.src_load  (cap_load),
		.src_data  ({cap2_c, cap1_c}),
		.src_busy  (cap_busy),
		.dst_valid (cap_v_b),
		.dst_data  (cap_in)
	);

	// Write address decode
	wire sel_ctrl = aw_a == `PWT_OFF_CTRL;
	wire sel_cmd  = aw_a == `PWT_OFF_CMD;
	wire sel_st   = aw_a == `PWT_OFF_STATUS;
	wire sel_u1s  = aw_a == `PWT_OFF_U1SET;
	wire sel_u1c  = aw_a == `PWT_OFF_U1CLR;
	wire sel_u2s  = aw_a == `PWT_OFF_U2SET;
	wire sel_u2c  = aw_a == `PWT_OFF_U2CLR;
	wire sel_inc  = aw_a == `PWT_OFF_INCFG;
	wire wr_go    = aw_full & w_full & ~bvalid;
	wire wr_cmp   = wr_go & ~busy;
	wire [2:0] flag_clr = (wr_go & sel_st) ? w_d[`PWT_ST_FLAG_LO +: 3] : 3'b000;

	// Compare byte pair merge: low lane, then the high nibble lane
	function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[CNT_W-1:8] : old[CNT_W-1:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// AXI handshakes: each ready is a single-cycle pulse from a flop
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_a    <= '0;
			w_d     <= '0;
			w_s     <= '0;
			bvalid  <= 1'b0;
			bresp   <= `PWT_RESP_OK;
		end
		else if (ce)
		begin
			awready <= ~awready & awvalid & ~aw_full & ~bvalid;
			wready  <= ~wready & wvalid & ~w_full & ~bvalid;
			if (awvalid && awready)
			begin
				aw_full <= 1'b1;
				aw_a    <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_full <= 1'b1;
				w_d    <= wdata;
				w_s    <= wstrb;
			end
			if (wr_go)
			begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= is_mapped(aw_a) ? `PWT_RESP_OK : `PWT_RESP_ERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end

	// Register writes; control, command and compare writes while a transfer is under way are dropped
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			ctrl_q  <= `PWT_CTRL_RST;
			cmp_q   <= '0;
			incfg_q <= `PWT_INCFG_RST;
			cmd_q   <= '0;
			launch  <= 1'b0;
		end
		else if (ce)
		begin
			if (launch && !hs_busy)
			begin
				launch <= 1'b0;
				cmd_q  <= '0;
			end
			if (wr_cmp && sel_ctrl)
			begin
				if (!ctrl_q.enable)
					ctrl_q <= w_d[`PWT_CTRL_W-1:0];
				else
					ctrl_q.enable <= w_d[0];
				launch <= 1'b1;
			end
			if (wr_cmp && sel_cmd && ctrl_q.enable)
			begin
				cmd_q  <= w_d[`PWT_CMD_W-1:0];
				launch <= 1'b1;
			end
			if (wr_cmp && sel_u1s)
				cmp_q.u1set <= merge(cmp_q.u1set, w_d, w_s);
			if (wr_cmp && sel_u1c)
				cmp_q.u1clr <= merge(cmp_q.u1clr, w_d, w_s);
			if (wr_cmp && sel_u2s)
				cmp_q.u2set <= merge(cmp_q.u2set, w_d, w_s);
			if (wr_cmp && sel_u2c)
				cmp_q.u2clr <= merge(cmp_q.u2clr, w_d, w_s);
			if (wr_go && sel_inc && !ctrl_q.enable)
				incfg_q <= w_d[`PWT_INCFG_W-1:0];
		end

	// Sticky event flags; a new event beats a clear in the same cycle
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			flags  <= 3'b000;
			cap1_b <= '0;
			cap2_b <= '0;
		end
		else if (ce)
		begin
			flags <= (flags & ~flag_clr) | {evt_cycle_end, evt_match2, evt_match1};
			if (cap_v_b)
			begin
				cap1_b <= cap_in[CNT_W-1:0];
				cap2_b <= cap_in[2*CNT_W-1:CNT_W];
			end
		end

	// Read side
	wire [31:0] st_word = {25'h0, fault_lat, flags, core_run, ~busy, ~busy};
	wire [31:0] rd_word =
		(araddr == `PWT_OFF_CTRL)   ? {22'h0, ctrl_q} :
		(araddr == `PWT_OFF_STATUS) ? st_word :
		(araddr == `PWT_OFF_U1SET)  ? {20'h0, cmp_q.u1set} :
		(araddr == `PWT_OFF_U1CLR)  ? {20'h0, cmp_q.u1clr} :
		(araddr == `PWT_OFF_U2SET)  ? {20'h0, cmp_q.u2set} :
		(araddr == `PWT_OFF_U2CLR)  ? {20'h0, cmp_q.u2clr} :
		(araddr == `PWT_OFF_INCFG)  ? {4'h0, incfg_q} :
		(araddr == `PWT_OFF_CAP1)   ? {20'h0, cap1_b} :
		(araddr == `PWT_OFF_CAP2)   ? {20'h0, cap2_b} :
		(araddr == `PWT_OFF_COUNT)  ? {20'h0, cnt} : 32'h00000000;

	// AXI read channel
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `PWT_RESP_OK;
		end
		else if (ce)
		begin
			arready <= ~arready & arvalid & ~rvalid;
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= is_mapped(araddr) ? `PWT_RESP_OK : `PWT_RESP_ERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end

	// Counter tick from the selected source: every cycle for the system clock, edges of sampled levels for RC and external
	wire rc_rise  = internal_rc_oscillator & ~rc_q;
	wire ext_rise = ext_clk_in & ~ext_q;
	wire tick     = (core_ctrl.src == PWT_SRC_SYS) |
		(core_ctrl.src == PWT_SRC_RC & rc_rise) | (core_ctrl.src == PWT_SRC_EXT & ext_rise);
	wire halted   = dbg_halt & ~core_ctrl.run_dbg;
	wire inject   = dbg_halt & core_ctrl.fault_inj;
	wire step     = core_run & tick & ~halted & ~(|halt_v);

	// Per channel: filter, blanking, mode action
	assign mode[0] = incfg_q.mode1;
	assign mode[1] = incfg_q.mode2;
	for (genvar i = 0; i < 2; i++)
	begin : g_evt
		assign raw[i]     = event_in[i] | inject;
		assign evt[i]     = filt_lvl[i] & ~(|blank_cnt);
		assign rise[i]    = evt[i] & ~evt_q[i];
		assign act[i]     = mode_act(mode[i]);
		assign gate_v[i]  = evt[i] & act[i].gate;
		assign halt_v[i]  = evt[i] & act[i].halt;
		assign rst_v[i]   = rise[i] & act[i].restart;
		assign skip_v[i]  = rise[i] & act[i].skip;
		assign cap_v[i]   = rise[i] & act[i].capture;
		assign latch_v[i] = rise[i] & act[i].latch;
		assign akill_v[i] = raw[i] & act[i].async_kill;
		// Level must differ for filt+1 cycles before it is taken
		always_ff @(posedge aclk)
			if (!aresetn)
			begin
				filt_cnt[i] <= 4'h0;
				filt_lvl[i] <= 1'b0;
				evt_q[i]    <= 1'b0;
			end
			else if (ce)
			begin
				evt_q[i] <= evt[i];
				if (raw[i] == filt_lvl[i])
					filt_cnt[i] <= 4'h0;
				else if (filt_cnt[i] >= incfg_q.filt)
				begin
					filt_lvl[i] <= raw[i];
					filt_cnt[i] <= 4'h0;
				end
				else
					filt_cnt[i] <= filt_cnt[i] + 4'h1;
			end
	end

	// Cycle state compare target per waveform mode
	wire dual = core_ctrl.wave == PWT_DUAL;
	wire [CNT_W-1:0] thr =
		(state == PWT_DT1) ? core_cmp.u1set :
		(state == PWT_OT1) ? (dual ? core_cmp.u2clr : core_cmp.u1clr) :
		(state == PWT_DT2) ? core_cmp.u2set :
		(dual ? `PWT_CNT_RST : core_cmp.u2clr);
	wire hit      = cnt == thr;
	wire half_end = (state == PWT_OT1) | (state == PWT_OT2);
	wire zero_cnt = hit & ((core_ctrl.wave == PWT_FOUR) |
		(core_ctrl.wave == PWT_TWO & half_end) | (core_ctrl.wave == PWT_ONE & state == PWT_OT2));
	wire dir_dn   = down ^ (dual & hit & half_end);
	wire cyc_end  = step & hit & (state == PWT_OT2);
	wire en_rise  = xv & xin.ctrl.enable & ~core_run;
	wire do_rst   = en_rise | (xv & xin.restart) | (|rst_v);
	wire cap_now1 = (xv & xin.cap1) | cap_v[0];
	wire cap_now2 = (xv & xin.cap2) | cap_v[1];
	wire blank_ld = step & hit & (|({state[2:0], state[3]} & incfg_q.blank_win));
	wire kill     = (|gate_v) | fault_lat | ~core_run;
	wire u1_on    = ~kill & (state == PWT_OT1);
	wire u2_on    = ~kill & (state == PWT_OT2);
	wire akill    = |akill_v;

	// Counter and cycle state
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			cnt   <= `PWT_CNT_RST;
			state <= PWT_DT1;
			down  <= 1'b0;
		end
		else if (ce)
		begin
			if (do_rst)
			begin
				cnt   <= `PWT_CNT_RST;
				state <= PWT_DT1;
				down  <= 1'b0;
			end
			else if (|skip_v)
				state <= PWT_DT2;
			else if (step)
			begin
				cnt  <= zero_cnt ? `PWT_CNT_RST : dir_dn ? cnt - 12'h001 : cnt + 12'h001;
				down <= dir_dn;
				if (hit)
					state <= pwt_state_t'({state[2:0], state[3]});
			end
		end

	// Core control, enable, faults, blanking, captures
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			core_ctrl <= `PWT_CTRL_RST;
			core_cmp  <= '0;
			core_run  <= 1'b0;
			eoc_pend  <= 1'b0;
			fault_lat <= 1'b0;
			blank_cnt <= '0;
			cap1_c    <= '0;
			cap2_c    <= '0;
			cap_pend  <= 1'b0;
			rc_q      <= 1'b0;
			ext_q     <= 1'b0;
		end
		else if (ce)
		begin
			rc_q  <= internal_rc_oscillator;
			ext_q <= ext_clk_in;
			if (xv)
			begin
				core_ctrl <= xin.ctrl;
				core_cmp  <= xin.cmp;
				core_run  <= xin.ctrl.enable;
				eoc_pend  <= xin.eoc & xin.ctrl.enable;
			end
			else if (cyc_end && eoc_pend)
			begin
				core_run <= 1'b0;
				eoc_pend <= 1'b0;
			end
			if (|latch_v)
				fault_lat <= 1'b1;
			else if (do_rst)
				fault_lat <= 1'b0;
			if (blank_ld)
				blank_cnt <= incfg_q.blank_len;
			else if (tick && (|blank_cnt) && !halted)
				blank_cnt <= blank_cnt - 12'h001;
			if (cap_now1)
				cap1_c <= cnt;
			if (cap_now2)
				cap2_c <= cnt;
			if (cap_now1 || cap_now2)
				cap_pend <= 1'b1;
			else if (cap_load)
				cap_pend <= 1'b0;
		end

	// Output flops and event pulses
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			o1_q          <= 1'b0;
			o2_q          <= 1'b0;
			o3_q          <= 1'b0;
			o4_q          <= 1'b0;
			evt_match1    <= 1'b0;
			evt_match2    <= 1'b0;
			evt_cycle_end <= 1'b0;
		end
		else if (ce)
		begin
			o1_q          <= u1_on;
			o2_q          <= u2_on;
			o3_q          <= (core_ctrl.full_bridge | core_ctrl.third_sel) ? u2_on : u1_on;
			o4_q          <= (~core_ctrl.full_bridge & core_ctrl.fourth_sel) ? u2_on : u1_on;
			evt_match1    <= step & hit & (state == PWT_DT1);
			evt_match2    <= step & hit & (state == PWT_DT2);
			evt_cycle_end <= cyc_end;
		end

	// Fault override acts without waiting for any edge
	assign wave_out_first  = o1_q & ~akill;
	assign wave_out_second = o2_q & ~akill;
	assign wave_out_third  = o3_q & ~akill;
	assign wave_out_fourth = o4_q & ~akill;
endmodule

// ---- pwt_bus_properties.sv ----
// Register bus timing checker for the power waveform timer
`timescale 1ns/10ps
`include "pwt_consts.svh"
module pwt_bus_properties (
	// Clock, reset, enable
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	// Write channels
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	// Read channels
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [1:0]  rresp,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		ce && awvalid && awready && wvalid && wready;
	endsequence
	// Address taken while the clock enable runs
	sequence s_rd_taken;
		ce && arvalid && arready;
	endsequence
	// Readies answer a valid, never idle bus
	a_aw_cause: assert property (awready |-> $past(awvalid)) else $error("awready without awvalid");
	a_w_cause: assert property (wready |-> $past(wvalid)) else $error("wready without wvalid");
	a_aw_pulse: assert property (awready && ce |=> !awready) else $error("awready longer than one cycle");
	// Responses stand until taken, so software never loses one
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_wr_answer: assert property (s_wr_taken |-> ##[1:3] bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_rd_taken |=> rvalid) else $error("read data late");
	a_err_zero: assert property (rvalid && rresp == `PWT_RESP_ERR |-> rdata == 32'h0000_0000)
		else $error("error read with data");
endmodule

// ---- pwt_stage_model.sv ----
// Half bridge power stage model counting shoot-through cycles
`timescale 1ns/10ps
module pwt_stage_model (
	// Clock
	input wire logic aclk,
	// Gate drives
	input wire logic hi_gate,
	input wire logic lo_gate,
	// Shoot-through count
	output int       overlaps
);
	// Both switches on would short the supply rail
	initial overlaps = 0;
	always @(posedge aclk) if (hi_gate === 1'b1 && lo_gate === 1'b1) overlaps <= overlaps + 1;
endmodule

// ---- tb_top.sv ----
// Testbench for the power waveform timer
`timescale 1ns/10ps
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dbg_halt;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  event_in, bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        wave_out_first, wave_out_second, wave_out_third, wave_out_fourth;
	logic        evt_match1, evt_match2, evt_cycle_end;
	int          num_errors, samples_checked, cyc, ov, n;
	// Sources other than the system clock stay idle
	pwt_top DUT (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.internal_rc_oscillator(1'b0), .ext_clk_in(1'b0), .dbg_halt, .event_in, .wave_out_first,
		.wave_out_second, .wave_out_third, .wave_out_fourth, .evt_match1, .evt_match2, .evt_cycle_end);
	pwt_stage_model u_stage (.aclk, .hi_gate(wave_out_first), .lo_gate(wave_out_second), .overlaps(ov));
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Master holds each channel until its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
		awaddr <= a; wdata <= dt; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 0;
			if (wready === 1'b1) wvalid <= 0;
		end while (bvalid !== 1'b1);
		// Ready stays up between calls, so no second assignment lands in one step
		chk({30'h0, bresp}, 32'h0);
	endtask
	task automatic rd_raw(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dt = rdata;
		rs = rresp;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		rd_raw(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// Counts cycle-end pulses over a fixed span
	task automatic cnt_end(output int c);
		c = 0;
		repeat (60) begin @(posedge aclk); c += (evt_cycle_end === 1'b1); end
	endtask
	// One full cycle: length, pulse counts, on times (clear minus set ticks)
	task automatic measure;
		int t0, m1, m2, h1, h2, h3, h4;
		do @(posedge aclk); while (evt_cycle_end !== 1'b1);
		t0 = cyc; m1 = 0; m2 = 0; h1 = 0; h2 = 0; h3 = 0; h4 = 0;
		do
		begin
			@(posedge aclk);
			m1 += (evt_match1 === 1'b1); m2 += (evt_match2 === 1'b1);
			h1 += (wave_out_first === 1'b1); h2 += (wave_out_second === 1'b1);
			h3 += (wave_out_third === 1'b1); h4 += (wave_out_fourth === 1'b1);
		end while (evt_cycle_end !== 1'b1);
		chk(cyc - t0, 32'd20);
		chk(m1, 1);
		chk(m2, 1);
		chk(h1, 4);
		chk(h2, 7);
		chk(h3, 4);
		chk(h4, 4);
	endtask
	task print_verdict;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard well above the run length
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	initial
	begin
		num_errors = 0; samples_checked = 0; aresetn = 0; dbg_halt = 0; event_in = 0;
		awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h08, 32'h3, 2'h0);
		rd(8'h2C, 32'h0, 2'h2);
		wr(8'h0C, 32'h004, 4'hF);
		wr(8'h10, 32'hF08, 4'h1);
		wr(8'h14, 32'hFFFFF00C, 4'hF);
		wr(8'h18, 32'h013, 4'hF);
		rd(8'h10, 32'h008, 2'h0);
		rd(8'h14, 32'h00C, 2'h0);
		// Channel 0 kills outputs asynchronously; system clock, one ramp
		wr(8'h1C, 32'h8, 4'hF);
		wr(8'h00, 32'h4, 4'hF);
		do rd_raw(8'h08, d, r); while (d[0] !== 1'b1);
		wr(8'h00, 32'h5, 4'hF);
		measure();
		measure();
		dbg_halt <= 1;
		cnt_end(n);
		chk(n, 0);
		dbg_halt <= 0;
		measure();
		do @(posedge aclk); while (wave_out_first !== 1'b1);
		event_in <= 2'b01;
		#1 chk({wave_out_first, wave_out_second, wave_out_third, wave_out_fourth}, 0);
		repeat (3) @(posedge aclk);
		event_in <= 2'b00;
		repeat (60) @(posedge aclk);
		chk({wave_out_first, wave_out_second, wave_out_third, wave_out_fourth}, 0);
		chk(ov, 0);
		wr(8'h04, 32'h2, 4'hF);
		repeat (100) @(posedge aclk);
		rd(8'h08, 32'h7B, 2'h0);
		cnt_end(n);
		chk(n, 0);
		wr(8'h08, 32'h38, 4'hF);
		rd(8'h08, 32'h43, 2'h0);
		print_verdict();
	end
endmodule
bind pwt_top pwt_bus_properties u_chk (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rresp, .rdata);
